// ### rtl/uhr_map.vh
`ifndef UHR_MAP_VH
`define UHR_MAP_VH
// register offsets
`define UHR_OFS_DATA      3'h0
`define UHR_OFS_IEN       3'h1
`define UHR_OFS_ISTAT     3'h2
`define UHR_OFS_LCTL      3'h3
`define UHR_OFS_MCTL      3'h4
`define UHR_OFS_LSTAT     3'h5
`define UHR_OFS_MSTAT     3'h6
`define UHR_OFS_SCRATCH   3'h7
// field positions
`define UHR_IEN_RXD       0
`define UHR_IEN_TXR       1
`define UHR_IEN_LS        2
`define UHR_IEN_MS        3
`define UHR_FCTL_EN       0
`define UHR_FCTL_RXRST    1
`define UHR_FCTL_TXRST    2
`define UHR_LCTL_DIV      7
`define UHR_MCTL_IRQ      3
// reset values
`define UHR_RST_DIVLO     8'h01
`define UHR_RST_ZERO      8'h00
// interrupt codes, highest priority first
`define UHR_ISC_LS        4'h6
`define UHR_ISC_TMO       4'hc
`define UHR_ISC_RXD       4'h4
`define UHR_ISC_TXR       4'h2
`define UHR_ISC_MS        4'h0
`define UHR_ISC_NONE      4'h1
// timeout: four characters plus twelve bits, in bit times
`define UHR_TMO_CHARS     4
`define UHR_TMO_BITS      12
`define UHR_BITS_PER_CHAR 10
`define UHR_TMO_BIT_TIMES (`UHR_TMO_CHARS * `UHR_BITS_PER_CHAR + `UHR_TMO_BITS)
`endif

// ### rtl/uhr_regs.v
module uhr_regs (
  input  wire       clock,
  input  wire       resetn,
  input  wire       io_rd,
  input  wire       io_wr,
  input  wire [2:0] io_addr,
  input  wire [7:0] io_wdata,
  output reg  [7:0] io_rdata,
  input  wire       rx_char_valid,
  input  wire [7:0] rx_char,
  input  wire       rx_char_err,
  input  wire       rx_overrun,
  input  wire       rx_parity_err,
  input  wire       rx_framing_err,
  input  wire       rx_break,
  input  wire       bit_tick,
  input  wire [3:0] modem_in_n,
  input  wire [3:0] modem_delta,
  input  wire       shifter_empty,
  input  wire       tx_take,
  output reg        tx_valid,
  output reg  [7:0] tx_data,
  output reg        irq_q,
  output reg  [7:0] line_control_q,
  output reg  [7:0] modem_control_q,
  output reg  [15:0] divisor_q,
  output reg  [1:0] rx_trigger_q
);
`include "uhr_map.vh"
  localparam DEPTH = 4;
  localparam [2:0] TRIG_LVL0 = 3'd1;
  localparam [2:0] TRIG_LVL1 = 3'd2;
  localparam [2:0] TRIG_LVL2 = 3'd3;
  localparam [2:0] TRIG_LVL3 = 3'd4;
  localparam [31:0] TMO_TOTAL = `UHR_TMO_BIT_TIMES;
  localparam [5:0]  TMO_LIMIT = TMO_TOTAL[5:0];

  // receive store: flip-flops with per-entry error flag
  reg [7:0] rx_mem_q [0:DEPTH-1];
  reg [DEPTH-1:0] rx_err_q;
  reg [1:0] rx_wp_q;
  reg [1:0] rx_rp_q;
  reg [2:0] rx_cnt_q;
  reg [7:0] ien_q;
  reg       fifo_en_q;
  reg [7:0] scratch_q;
  reg       ls_pend_q;
  reg       ms_pend_q;
  reg       txr_pend_q;
  reg       tmo_pend_q;
  reg [5:0] tmo_cnt_q;
  reg       thr_empty_prev_q;
  reg       ien_txr_prev_q;
  reg       ovr_q;
  reg [7:0] rx_single_q;
  reg       rx_single_full_q;
  reg       char_err_hold_q;
  // head_turn_q: the head character was replaced in the last cycle
  reg       head_bad_prev_q;
  reg       head_turn_q;

  function [2:0] trig_of;
    input [1:0] sel;
    begin
      case (sel)
        2'd0: trig_of = TRIG_LVL0;
        2'd1: trig_of = TRIG_LVL1;
        2'd2: trig_of = TRIG_LVL2;
        default: trig_of = TRIG_LVL3;
      endcase
    end
  endfunction

  wire       div_sel   = line_control_q[`UHR_LCTL_DIV];
  wire       rd_data   = io_rd && io_addr == `UHR_OFS_DATA && !div_sel;
  wire       wr_data   = io_wr && io_addr == `UHR_OFS_DATA && !div_sel;
  wire       rd_istat  = io_rd && io_addr == `UHR_OFS_ISTAT;
  wire       rd_lstat  = io_rd && io_addr == `UHR_OFS_LSTAT;
  wire       rd_mstat  = io_rd && io_addr == `UHR_OFS_MSTAT;
  wire       wr_fctl   = io_wr && io_addr == `UHR_OFS_ISTAT;
  wire       rx_rst    = wr_fctl && io_wdata[`UHR_FCTL_EN] && io_wdata[`UHR_FCTL_RXRST];
  wire       rx_have   = fifo_en_q ? (rx_cnt_q != 3'd0) : rx_single_full_q;
  wire       rx_pop    = rd_data && rx_have;
  wire       rx_push   = rx_char_valid && (fifo_en_q ? rx_cnt_q != DEPTH : 1'b1);
  wire [7:0] rx_head   = fifo_en_q ? rx_mem_q[rx_rp_q] : rx_single_q;
  wire       head_err  = fifo_en_q ? rx_err_q[rx_rp_q] && rx_cnt_q != 3'd0 : char_err_hold_q;
  wire       any_err   = |(rx_err_q);
  // a flawed character raises line status once, on reaching the head,
  // so that a status read really clears it while the character waits
  wire       head_bad  = head_err && rx_have;

  // transmit side goes through the buffer; a data write is dropped when it is full
  wire       txf_ready;
  wire       txf_out_valid;
  wire [7:0] txf_out_data;
  wire       tx_push   = wr_data && txf_ready;
  // the staging register counts as holding, so bit 5 drops as soon as a byte is written
  wire       thr_empty = !txf_out_valid && !tx_valid;
  wire       tx_idle   = thr_empty && shifter_empty;

  uhr_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txf (
    .clock     (clock),
    .resetn    (resetn),
    .flush     (wr_fctl && io_wdata[`UHR_FCTL_EN] && io_wdata[`UHR_FCTL_TXRST]),
    .in_valid  (tx_push),
    .in_ready  (txf_ready),
    .in_data   (io_wdata),
    .out_valid (txf_out_valid),
    .out_ready (!tx_valid || tx_take),
    .out_data  (txf_out_data)
  );

  wire rxd_src = fifo_en_q ? (rx_cnt_q >= trig_of(rx_trigger_q)) : rx_single_full_q;
  wire ls_en   = ien_q[`UHR_IEN_LS] && ls_pend_q;
  wire tmo_en  = ien_q[`UHR_IEN_RXD] && tmo_pend_q && fifo_en_q;
  wire rxd_en  = ien_q[`UHR_IEN_RXD] && rxd_src;
  wire txr_en  = ien_q[`UHR_IEN_TXR] && txr_pend_q;
  wire ms_en   = ien_q[`UHR_IEN_MS] && ms_pend_q;
  // no enabled source leaves polled mode with status bits only
  wire [3:0] isc = ls_en  ? `UHR_ISC_LS  :
                   tmo_en ? `UHR_ISC_TMO :
                   rxd_en ? `UHR_ISC_RXD :
                   txr_en ? `UHR_ISC_TXR :
                   ms_en  ? `UHR_ISC_MS  : `UHR_ISC_NONE;
  wire [7:0] istat = {fifo_en_q, fifo_en_q, 2'b00, isc};
  wire [7:0] lstat = {any_err && fifo_en_q, tx_idle, thr_empty, rx_break && head_err,
                      rx_framing_err && head_err, rx_parity_err && head_err, ovr_q, rx_have};
  wire [7:0] mstat = {~modem_in_n, modem_delta};

  always @(posedge clock) begin
    if (!resetn) begin
      rx_wp_q <= 2'd0;
      rx_rp_q <= 2'd0;
      rx_cnt_q <= 3'd0;
      rx_err_q <= {DEPTH{1'b0}};
      rx_single_q <= `UHR_RST_ZERO;
      rx_single_full_q <= 1'b0;
      char_err_hold_q <= 1'b0;
    end else if (rx_rst) begin
      rx_wp_q <= 2'd0;
      rx_rp_q <= 2'd0;
      rx_cnt_q <= 3'd0;
      rx_err_q <= {DEPTH{1'b0}};
    end else begin
      if (rx_push && fifo_en_q) begin
        rx_mem_q[rx_wp_q] <= rx_char;
        rx_err_q[rx_wp_q] <= rx_char_err;
        rx_wp_q <= rx_wp_q + 2'd1;
      end
      if (rx_pop && fifo_en_q) begin
        rx_rp_q <= rx_rp_q + 2'd1;
        if (!(rx_push && rx_wp_q == rx_rp_q))
          rx_err_q[rx_rp_q] <= 1'b0;
      end
      if (fifo_en_q)
        rx_cnt_q <= rx_cnt_q + {2'b00, rx_push} - {2'b00, rx_pop};
      if (!fifo_en_q && rx_push) begin
        rx_single_q <= rx_char;
        char_err_hold_q <= rx_char_err;
      end
      // a new character beats the read that empties the holding register
      if (!fifo_en_q && rx_push)
        rx_single_full_q <= 1'b1;
      else if (rx_pop)
        rx_single_full_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      ien_q <= `UHR_RST_ZERO;
      fifo_en_q <= 1'b0;
      rx_trigger_q <= 2'd0;
      line_control_q <= `UHR_RST_ZERO;
      modem_control_q <= `UHR_RST_ZERO;
      scratch_q <= `UHR_RST_ZERO;
      divisor_q <= {`UHR_RST_ZERO, `UHR_RST_DIVLO};
    end else if (io_wr) begin
      if (io_addr == `UHR_OFS_DATA && div_sel)
        divisor_q[7:0] <= io_wdata;
      else if (io_addr == `UHR_OFS_IEN && div_sel)
        divisor_q[15:8] <= io_wdata;
      else if (io_addr == `UHR_OFS_IEN)
        ien_q <= {4'h0, io_wdata[3:0]};
      else if (io_addr == `UHR_OFS_ISTAT) begin
        fifo_en_q <= io_wdata[`UHR_FCTL_EN];
        if (io_wdata[`UHR_FCTL_EN])
          rx_trigger_q <= io_wdata[7:6];
      end else if (io_addr == `UHR_OFS_LCTL)
        line_control_q <= io_wdata;
      else if (io_addr == `UHR_OFS_MCTL)
        modem_control_q <= {3'b000, io_wdata[4:0]};
      else if (io_addr == `UHR_OFS_SCRATCH)
        scratch_q <= io_wdata;
    end
  end

  // pending flags: a setting event wins over a clearing access in the same cycle, except timeout, where a data read wins
  always @(posedge clock) begin
    if (!resetn) begin
      ls_pend_q <= 1'b0;
      ovr_q <= 1'b0;
      ms_pend_q <= 1'b0;
      txr_pend_q <= 1'b0;
      tmo_pend_q <= 1'b0;
      tmo_cnt_q <= 6'd0;
      thr_empty_prev_q <= 1'b1;
      ien_txr_prev_q <= 1'b0;
      head_bad_prev_q <= 1'b0;
      head_turn_q <= 1'b0;
    end else begin
      thr_empty_prev_q <= thr_empty;
      ien_txr_prev_q <= ien_q[`UHR_IEN_TXR];
      head_bad_prev_q <= head_bad;
      head_turn_q <= rx_pop || (rx_push && !fifo_en_q);
      if (rx_overrun)
        ovr_q <= 1'b1;
      else if (rd_lstat)
        ovr_q <= 1'b0;
      // errors count once the flawed character stands at the head
      if (rx_overrun || (head_bad && (!head_bad_prev_q || head_turn_q)))
        ls_pend_q <= 1'b1;
      else if (rd_lstat)
        ls_pend_q <= 1'b0;
      // delta bits are levels: a read clears the flag only once they have dropped
      if (|modem_delta)
        ms_pend_q <= 1'b1;
      else if (rd_mstat)
        ms_pend_q <= 1'b0;
      if ((thr_empty && !thr_empty_prev_q) ||
          (thr_empty && ien_q[`UHR_IEN_TXR] && !ien_txr_prev_q))
        txr_pend_q <= 1'b1;
      else if (rd_istat && isc == `UHR_ISC_TXR || tx_push || !thr_empty)
        txr_pend_q <= 1'b0;
      // the counter only ages unread data; any data read or stored arrival restarts it
      if (!rx_have || rd_data || rx_push)
        tmo_cnt_q <= 6'd0;
      else if (bit_tick && tmo_cnt_q != TMO_LIMIT)
        tmo_cnt_q <= tmo_cnt_q + 6'd1;
      if (rx_have && bit_tick && tmo_cnt_q == TMO_LIMIT - 6'd1 && !rd_data)
        tmo_pend_q <= 1'b1;
      else if (rd_data)
        tmo_pend_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      io_rdata <= `UHR_RST_ZERO;
      irq_q <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= `UHR_RST_ZERO;
    end else begin
      irq_q <= modem_control_q[`UHR_MCTL_IRQ] && isc != `UHR_ISC_NONE;
      if (!tx_valid || tx_take) begin
        tx_valid <= txf_out_valid;
        tx_data <= txf_out_data;
      end
      if (io_rd) begin
        if (io_addr == `UHR_OFS_DATA)
          io_rdata <= div_sel ? divisor_q[7:0] : rx_head;
        else if (io_addr == `UHR_OFS_IEN)
          io_rdata <= div_sel ? divisor_q[15:8] : ien_q;
        else if (io_addr == `UHR_OFS_ISTAT)
          io_rdata <= istat;
        else if (io_addr == `UHR_OFS_LCTL)
          io_rdata <= line_control_q;
        else if (io_addr == `UHR_OFS_MCTL)
          io_rdata <= modem_control_q;
        else if (io_addr == `UHR_OFS_LSTAT)
          io_rdata <= lstat;
        else if (io_addr == `UHR_OFS_MSTAT)
          io_rdata <= mstat;
        else
          io_rdata <= scratch_q;
      end
    end
  end
endmodule

module uhr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4
) (
  input  wire             clock,
  input  wire             resetn,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  // pointers are two bits wide and wrap freely, so the depth must stay at 4
  reg [1:0]       wp_q;
  reg [1:0]       rp_q;
  reg [2:0]       cnt_q;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = cnt_q != DEPTH;
  assign out_valid = cnt_q != 3'd0;
  assign out_data  = mem_q[rp_q];
  always @(posedge clock) begin
    if (!resetn || flush) begin
      wp_q <= 2'd0;
      rp_q <= 2'd0;
      cnt_q <= 3'd0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= wp_q + 2'd1;
      end
      if (pop)
        rp_q <= rp_q + 2'd1;
      cnt_q <= cnt_q + {2'b00, push} - {2'b00, pop};
    end
  end
endmodule

// ### tb/uhr_regs_monitor.sv
module uhr_regs_monitor (
  input logic        clock,
  input logic        resetn,
  input logic        io_rd,
  input logic [2:0]  io_addr,
  input logic [7:0]  io_rdata,
  input logic        irq_q,
  input logic        tx_valid,
  input logic [7:0]  tx_data,
  input logic        tx_take,
  input logic [7:0]  line_control_q,
  input logic [7:0]  modem_control_q,
  input logic [15:0] divisor_q,
  input logic [3:0]  modem_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_isr;
  assign rd_isr = io_rd && io_addr == 3'h2;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_reset_quiet: assert property (
    $rose(resetn) |-> !irq_q && io_rdata == 8'h00 && !tx_valid)
    else $error("outputs not idle after reset");
  a_gate_blocks_irq: assert property (
    !modem_control_q[3] && !$past(modem_control_q[3]) |-> !irq_q)
    else $error("interrupt line high with gate off");
  a_status_upper: assert property (
    rd_isr |=> io_rdata[5:4] == 2'b00 && io_rdata[7] == io_rdata[6])
    else $error("status upper bits malformed");
  a_status_code: assert property (
    rd_isr |=> io_rdata[3:0] inside {4'h6, 4'hc, 4'h4, 4'h2, 4'h0, 4'h1})
    else $error("status code not a legal level");
  a_enable_upper: assert property (
    io_rd && io_addr == 3'h1 && !line_control_q[7] |=> io_rdata[7:4] == 4'h0)
    else $error("enable register upper bits set");
  a_divisor_low: assert property (
    io_rd && io_addr == 3'h0 && line_control_q[7] |=> io_rdata == divisor_q[7:0])
    else $error("divisor low byte read wrong");
  a_divisor_high: assert property (
    io_rd && io_addr == 3'h1 && line_control_q[7] |=> io_rdata == divisor_q[15:8])
    else $error("divisor high byte read wrong");
  a_line_empty_order: assert property (
    io_rd && io_addr == 3'h5 |=> !io_rdata[6] || io_rdata[5])
    else $error("shifter empty flagged with holding full");
  a_modem_inputs: assert property (
    io_rd && io_addr == 3'h6 |=> io_rdata[7:4] == ~$past(modem_in_n))
    else $error("modem inputs not shown inverted");
  a_tx_hold: assert property (tx_valid && !tx_take |=> tx_valid && $stable(tx_data))
    else $error("transmit byte withdrawn before take");
  c_timeout_seen: cover property (rd_isr ##1 io_rdata[3:0] == 4'hc);
  c_irq_raised: cover property ($rose(irq_q));
  c_tx_taken: cover property (tx_valid && tx_take);
endmodule
bind uhr_regs uhr_regs_monitor mon (.clock, .resetn, .io_rd, .io_addr, .io_rdata, .irq_q,
  .tx_valid, .tx_data, .tx_take, .line_control_q, .modem_control_q, .divisor_q, .modem_in_n);

// ### tb/uhr_engine_model.sv
module uhr_engine_model (
  output logic       tx_take,
  output logic       shifter_empty,
  output logic       bit_tick,
  input  logic       clock,
  input  logic       resetn,
  input  logic       tx_valid,
  input  logic [7:0] tx_data,
  input  logic       slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] tick_q;
  logic [4:0] busy_q;
  logic [7:0] got[$];
  // one take per character, then the shifter stays busy for 20 clock cycles
  always @(posedge clock) begin
    if (!resetn) begin
      tick_q <= 4'h0;
      busy_q <= 5'h00;
      tx_take <= 1'b0;
    end else begin
      tick_q <= tick_q + 4'h1;
      tx_take <= 1'b0;
      if (tx_take) begin
        got.push_back(tx_data);
        busy_q <= 5'h14;
      end else if (busy_q != 5'h00) begin
        busy_q <= busy_q - 5'h01;
      end else if (tx_valid && !slow) begin
        tx_take <= 1'b1;
      end
    end
  end
  assign bit_tick = tick_q == 4'hf;
  assign shifter_empty = busy_q == 5'h00 && !tx_take;
endmodule

// ### tb/tb.sv
`define CHK(v, e) begin samples_checked++; if ((v) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h exp %h", $time, v, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, resetn = 0, io_rd = 0, io_wr = 0, rx_char_valid = 0, rx_char_err = 0;
  logic slow = 0, rx_overrun = 0, tx_take, tx_valid, irq_q, bit_tick, shifter_empty;
  logic [2:0]  io_addr = 3'h0;
  logic [7:0]  io_wdata = 8'h00, rx_char = 8'h00, io_rdata, tx_data;
  logic [7:0]  line_control_q, modem_control_q;
  logic [3:0]  modem_in_n = 4'ha, modem_delta = 4'h0;
  logic [15:0] divisor_q;
  logic [1:0]  rx_trigger_q;
  int          error_cnt = 0, samples_checked = 0;
  always #50 clock = ~clock;
  uhr_regs dut (.clock, .resetn, .io_rd, .io_wr, .io_addr, .io_wdata, .io_rdata, .rx_char_valid,
    .rx_char, .rx_char_err, .rx_overrun, .rx_parity_err(1'b0), .rx_framing_err(1'b0),
    .rx_break(1'b0), .bit_tick, .modem_in_n, .modem_delta, .shifter_empty, .tx_take, .tx_valid,
    .tx_data, .irq_q, .line_control_q, .modem_control_q, .divisor_q, .rx_trigger_q);
  uhr_engine_model eng (.clock, .resetn, .tx_valid, .tx_data, .slow, .tx_take, .shifter_empty,
    .bit_tick);
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= v;
    @(posedge clock);
    io_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge clock);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clock);
    io_rd <= 1'b0;
    #1 `CHK(io_rdata & m, e)
  endtask
  task automatic push(input logic [7:0] v, input logic e);
    @(posedge clock);
    rx_char_valid <= 1'b1;
    rx_char <= v;
    rx_char_err <= e;
    @(posedge clock);
    rx_char_valid <= 1'b0;
  endtask
  task automatic conclude;
    $display("mismatches %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    rd(3'h2, 8'h01);
    rd(3'h5, 8'h60);
    rd(3'h1, 8'h00);
    wr(3'h7, 8'ha5);
    wr(3'h5, 8'h00);
    rd(3'h7, 8'ha5);
    rd(3'h5, 8'h60);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    rd(3'h0, 8'h34);
    rd(3'h1, 8'h12);
    `CHK(divisor_q, 16'h1234)
    wr(3'h3, 8'h03);
    rd(3'h3, 8'h03);
    rd(3'h1, 8'h00);
    wr(3'h2, 8'hc0);
    rd(3'h2, 8'h01);
    `CHK(rx_trigger_q, 2'h0)
    wr(3'h2, 8'h41);
    rd(3'h2, 8'hc1);
    `CHK(rx_trigger_q, 2'h1)
    wr(3'h4, 8'h08);
    rd(3'h4, 8'h08);
    wr(3'h1, 8'h01);
    push(8'h11, 1'b0);
    rd(3'h5, 8'h01, 8'h01);
    rd(3'h2, 8'hc1);
    push(8'h22, 1'b0);
    rd(3'h2, 8'hc4);
    `CHK(irq_q, 1'b1)
    rd(3'h0, 8'h11);
    rd(3'h2, 8'hc1);
    rd(3'h0, 8'h22);
    rd(3'h5, 8'h00, 8'h01);
    push(8'h33, 1'b0);
    repeat (960) @(posedge clock);
    rd(3'h2, 8'hcc);
    rd(3'h0, 8'h33);
    rd(3'h2, 8'hc1);
    wr(3'h1, 8'h05);
    push(8'h44, 1'b1);
    push(8'h55, 1'b0);
    rd(3'h2, 8'hc6);
    rd(3'h5, 8'h80, 8'h80);
    rd(3'h2, 8'hc4);
    rd(3'h0, 8'h44);
    rd(3'h0, 8'h55);
    rd(3'h5, 8'h60);
    @(posedge clock);
    rx_overrun <= 1'b1;
    @(posedge clock);
    rx_overrun <= 1'b0;
    rd(3'h2, 8'hc6);
    rd(3'h5, 8'h62);
    rd(3'h2, 8'hc1);
    wr(3'h1, 8'h02);
    rd(3'h2, 8'hc2);
    rd(3'h2, 8'hc1);
    wr(3'h0, 8'h5a);
    repeat (60) @(posedge clock);
    `CHK(eng.got[0], 8'h5a)
    rd(3'h2, 8'hc2);
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) wr(3'h0, 8'(8'h10 + i));
    rd(3'h5, 8'h00, 8'h60);
    slow <= 1'b0;
    repeat (200) @(posedge clock);
    `CHK(eng.got.size(), 5)
    for (int i = 0; i < 4; i++) `CHK(eng.got[i + 1], 8'(8'h10 + i))
    rd(3'h5, 8'h60);
    rd(3'h2, 8'hc2);
    wr(3'h1, 8'h08);
    modem_delta <= 4'h1;
    rd(3'h2, 8'hc0);
    `CHK(irq_q, 1'b1)
    wr(3'h4, 8'h00);
    @(posedge clock);
    #1 `CHK(irq_q, 1'b0)
    wr(3'h4, 8'h08);
    modem_delta <= 4'h0;
    rd(3'h6, 8'h50, 8'hf0);
    rd(3'h2, 8'hc1);
    wr(3'h1, 8'h00);
    push(8'h77, 1'b0);
    rd(3'h2, 8'hc1);
    rd(3'h5, 8'h01, 8'h01);
    rd(3'h0, 8'h77);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rd(3'h2, 8'h01);
    rd(3'h5, 8'h60);
    `CHK(divisor_q, 16'h0001)
    `CHK(irq_q, 1'b0)
    conclude();
  end
endmodule
